// ### hw/dpr_pkg.sv
// dpr_pkg: offsets, field positions, reset values and rate codes for the
// datapath setup and receive mode register pair.
// assumes an 8-bit local register port with byte offsets as addresses.
package dpr_pkg;
  localparam logic [7:0] DATAPATH_SETUP_OFS     = 8'h22;
  localparam logic [7:0] RECEIVE_MODE_STATE_OFS = 8'h23;
  localparam logic [7:0] DATAPATH_SETUP_RST     = 8'h00;
  localparam logic [7:0] DATA_ZERO              = 8'h00;
  localparam logic       AUTO_AUDIO_RST         = 1'h1;
  // datapath setup fields
  localparam int FORWARD_LOAD_LOCK_BIT  = 7;
  localparam int VIDEO_PASS_UNGATED_BIT = 6;
  localparam int DATA_ENABLE_POL_BIT    = 5;
  localparam int AUX_AUDIO_SUPPR_BIT    = 4;
  localparam int QUAD_OVERRIDE_BIT      = 3;
  localparam int NARROW_COLOUR_BIT      = 2;
  localparam int AUDIO_INBAND_BIT       = 1;
  localparam int QUAD_AUDIO_BIT         = 0;
  localparam int LOADABLE_TOP           = 6;
  // receive mode fields
  localparam int RETURN_RATE_SEL_BIT    = 6;
  localparam int AUTO_AUDIO_BIT         = 5;
  localparam int RETURN_FAST_RATE_BIT   = 4;
  localparam int CABLE_COAX_BIT         = 3;
  localparam int REPEATER_BIT           = 2;
  typedef enum logic [1:0] {
    RATE_5M  = 2'b00,
    RATE_10M = 2'b01,
    RATE_20M = 2'b10
  } dpr_rate_t;
endpackage

// ### hw/dpr_regs.sv
// dpr_regs: datapath setup and receive mode registers with forward-channel
// load path and decoded control outputs.
// assumes synchronous inputs on sys_clk; strap pins stable around reset.
//
// Contract
// - lock bit set ignores forward-channel loads
// - lock clear lets forward load bits 6..0
// - ungated bit passes colour ignoring data enable
// - ungated mode disables protection, blocks audio
// - polarity bit selects data enable sense
// - suppress bit stops packetized audio output
// - override takes quad setting from bit 0
// - colour bit selects 18 or 24 bit
// - no surround audio in repeater 18-bit
// - transport bit selects in-band or island
// - quad audio bit enables four-channel audio
// - datapath register resets to zero
// - rate select picks 5 or 10 Mbps
// - fast bit forces 20 Mbps, ignores select
// - auto audio resets to one, auto-detects
// - fast bit loaded from strap on the first clock after reset release
// - cable bit strap loaded, coax or pair
// - repeater bit read-only from strap
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dpr_regs (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdData,
  input  wire logic        fwdLoad,
  input  wire logic [6:0]  fwdData,
  input  wire logic        strapFastRate,
  input  wire logic        strapCoax,
  input  wire logic        strapRepeater,
  input  wire logic        dataEnableIn,
  output logic             colourPass,
  output logic             protectDisable,
  output logic             audioOutEnable,
  output logic             narrowColour,
  output logic             audioInBand,
  output logic             quadAudio,
  output logic             surroundAllowed,
  output logic             autoAudio,
  output logic             cableCoax,
  output dpr_pkg::dpr_rate_t returnRate
);

  ////////////////////////////////////////////////////////////////////////////
  // datapath setup register
  logic [7:0] dpSetup_r;
  logic       lock;
  logic       wrDp;
  logic       wrRm;

  assign lock = dpSetup_r[dpr_pkg::FORWARD_LOAD_LOCK_BIT];
  assign wrDp = regWrite && (regAddr == dpr_pkg::DATAPATH_SETUP_OFS);
  assign wrRm = regWrite && (regAddr == dpr_pkg::RECEIVE_MODE_STATE_OFS);

  // local write wins over a same-cycle forward load; software intent first
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dpSetup_r <= dpr_pkg::DATAPATH_SETUP_RST;
    end else if (wrDp) begin
      dpSetup_r <= regWrData;
    end else if (fwdLoad && !lock) begin
      dpSetup_r[dpr_pkg::LOADABLE_TOP:0] <= fwdData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive mode register
  logic rateSel_r;
  logic autoAudio_r;
  logic fastRate_r;
  logic coax_r;
  logic repeater_r;
  logic strapPending_r;

  // straps caught on the first clock after reset release, not under reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      strapPending_r <= 1'h1;
    end else begin
      strapPending_r <= 1'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rateSel_r   <= 1'h0;
      autoAudio_r <= dpr_pkg::AUTO_AUDIO_RST;
      fastRate_r  <= 1'h0;
      coax_r      <= 1'h0;
      repeater_r  <= 1'h0;
    end else if (strapPending_r) begin
      // strap cycle: only the strap-loaded bits lose a same-cycle write
      if (wrRm) begin
        rateSel_r   <= regWrData[dpr_pkg::RETURN_RATE_SEL_BIT];
        autoAudio_r <= regWrData[dpr_pkg::AUTO_AUDIO_BIT];
      end
      fastRate_r <= strapFastRate;
      coax_r     <= strapCoax;
      repeater_r <= strapRepeater;
    end else if (wrRm) begin
      rateSel_r   <= regWrData[dpr_pkg::RETURN_RATE_SEL_BIT];
      autoAudio_r <= regWrData[dpr_pkg::AUTO_AUDIO_BIT];
      fastRate_r  <= regWrData[dpr_pkg::RETURN_FAST_RATE_BIT];
      coax_r      <= regWrData[dpr_pkg::CABLE_COAX_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port
  logic [7:0] rmView;

  always_comb begin
    rmView = dpr_pkg::DATA_ZERO;
    rmView[dpr_pkg::RETURN_RATE_SEL_BIT]  = rateSel_r;
    rmView[dpr_pkg::AUTO_AUDIO_BIT]       = autoAudio_r;
    rmView[dpr_pkg::RETURN_FAST_RATE_BIT] = fastRate_r;
    rmView[dpr_pkg::CABLE_COAX_BIT]       = coax_r;
    rmView[dpr_pkg::REPEATER_BIT]         = repeater_r;
  end

  // unmapped addresses read zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      regRdData <= dpr_pkg::DATA_ZERO;
    end else if (regRead && regAddr == dpr_pkg::DATAPATH_SETUP_OFS) begin
      regRdData <= dpSetup_r;
    end else if (regRead && regAddr == dpr_pkg::RECEIVE_MODE_STATE_OFS) begin
      regRdData <= rmView;
    end else begin
      regRdData <= dpr_pkg::DATA_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded controls
  logic ungated;
  logic deActive;

  assign ungated = dpSetup_r[dpr_pkg::VIDEO_PASS_UNGATED_BIT];
  assign deActive = dataEnableIn ^ dpSetup_r[dpr_pkg::DATA_ENABLE_POL_BIT];

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      colourPass      <= 1'h0;
      protectDisable  <= 1'h0;
      audioOutEnable  <= 1'h0;
      narrowColour    <= 1'h0;
      audioInBand     <= 1'h0;
      quadAudio       <= 1'h0;
      surroundAllowed <= 1'h0;
    end else begin
      colourPass     <= ungated || deActive;
      protectDisable <= ungated;
      audioOutEnable <= !ungated &&
                        !dpSetup_r[dpr_pkg::AUX_AUDIO_SUPPR_BIT];
      narrowColour   <= dpSetup_r[dpr_pkg::NARROW_COLOUR_BIT];
      audioInBand    <= dpSetup_r[dpr_pkg::AUDIO_INBAND_BIT];
      quadAudio      <= dpSetup_r[dpr_pkg::QUAD_OVERRIDE_BIT] &&
                        dpSetup_r[dpr_pkg::QUAD_AUDIO_BIT];
      // surround needs the quad path; repeater at 18 bit forbids it
      surroundAllowed <= !(repeater_r &&
                           dpSetup_r[dpr_pkg::NARROW_COLOUR_BIT]) &&
                         dpSetup_r[dpr_pkg::QUAD_OVERRIDE_BIT] &&
                         dpSetup_r[dpr_pkg::QUAD_AUDIO_BIT];
    end
  end

  assign autoAudio = autoAudio_r;
  assign cableCoax = coax_r;

  // rate changes glitch the back channel; host arms auto-ack first
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      returnRate <= dpr_pkg::RATE_5M;
    end else if (fastRate_r) begin
      returnRate <= dpr_pkg::RATE_20M;
    end else if (rateSel_r) begin
      returnRate <= dpr_pkg::RATE_10M;
    end else begin
      returnRate <= dpr_pkg::RATE_5M;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence sLockedLoad;
    fwdLoad && lock && !wrDp;
  endsequence

  a_lock_holds_value: assert property (@(posedge sys_clk) disable iff (sys_rst)
    sLockedLoad |=> $stable(dpSetup_r))
    else $error("locked register changed on forward load");

  a_forward_load_lands: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    fwdLoad && !lock && !wrDp |=> dpSetup_r[6:0] == $past(fwdData)
      && dpSetup_r[7] == $past(dpSetup_r[7]))
    else $error("forward load not applied");

  a_ungated_pass: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ungated |=> colourPass && protectDisable && !audioOutEnable)
    else $error("ungated mode outputs wrong");

  a_polarity_sense: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !ungated |=> colourPass == ($past(dataEnableIn) ^
                 $past(dpSetup_r[5])))
    else $error("data enable sense wrong");

  a_quad_override: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !dpSetup_r[3] |=> !quadAudio)
    else $error("quad audio without override");

  a_quad_enable: assert property (@(posedge sys_clk) disable iff (sys_rst)
    dpSetup_r[dpr_pkg::QUAD_OVERRIDE_BIT] |=>
      quadAudio == $past(dpSetup_r[dpr_pkg::QUAD_AUDIO_BIT]))
    else $error("quad audio enable wrong");

  a_narrow_select: assert property (@(posedge sys_clk) disable iff (sys_rst)
    1'b1 |=> narrowColour ==
      $past(dpSetup_r[dpr_pkg::NARROW_COLOUR_BIT]))
    else $error("colour width select wrong");

  a_inband_select: assert property (@(posedge sys_clk) disable iff (sys_rst)
    1'b1 |=> audioInBand ==
      $past(dpSetup_r[dpr_pkg::AUDIO_INBAND_BIT]))
    else $error("audio transport select wrong");

  a_audio_suppress: assert property (@(posedge sys_clk) disable iff (sys_rst)
    dpSetup_r[dpr_pkg::AUX_AUDIO_SUPPR_BIT] |=> !audioOutEnable)
    else $error("audio output while suppressed");

  a_repeater_readonly: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    wrRm && !strapPending_r |=> $stable(repeater_r))
    else $error("repeater bit changed by write");

  a_no_surround: assert property (@(posedge sys_clk) disable iff (sys_rst)
    repeater_r && dpSetup_r[2] |=> !surroundAllowed)
    else $error("surround in repeater narrow mode");

  a_fast_rate_wins: assert property (@(posedge sys_clk) disable iff (sys_rst)
    fastRate_r |=> returnRate == dpr_pkg::RATE_20M)
    else $error("fast rate not applied");

  a_slow_rate_sel: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !fastRate_r |=> returnRate ==
      ($past(rateSel_r) ? dpr_pkg::RATE_10M : dpr_pkg::RATE_5M))
    else $error("rate select wrong");

  a_strap_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
    strapPending_r |=> fastRate_r == $past(strapFastRate)
      && coax_r == $past(strapCoax))
    else $error("strap not captured");

  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    regRead && regAddr == dpr_pkg::RECEIVE_MODE_STATE_OFS |=>
      regRdData[7] == 1'h0 && regRdData[1:0] == 2'h0)
    else $error("reserved bits not zero");

  a_reset_zero: assert property (@(posedge sys_clk)
    $past(sys_rst) && !sys_rst |-> dpSetup_r == 8'h00 && autoAudio_r)
    else $error("reset values wrong");

endmodule
`default_nettype wire

// ### bench/dpr_remote_model.sv
// dpr_remote_model: far-end serializer that pushes datapath settings.
// assumes the bench calls sendConfig between its own register accesses.
`timescale 1ns/1ps
`default_nettype none
module dpr_remote_model (
  input  wire logic       sys_clk,
  output logic            fwdLoad,
  output logic      [6:0] fwdData
);
  initial begin
    fwdLoad = 1'b0;
    fwdData = 7'h55;
  end
  // one-cycle push; data inverts afterwards so a stale value never matches
  task automatic sendConfig(input logic [6:0] cfg);
    @(posedge sys_clk);
    fwdLoad <= 1'b1;
    fwdData <= cfg;
    @(posedge sys_clk);
    fwdLoad <= 1'b0;
    fwdData <= ~cfg;
  endtask
endmodule
`default_nettype wire

// ### bench/tb.sv
// tb: register pair bench, local port accesses plus forward-channel loads.
// assumes straps fast, coax and repeater all tied high for the whole run.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0, sys_rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
  logic dataEnableIn = 1'b0, fwdLoad, colourPass, protectDisable;
  logic audioOutEnable, narrowColour, audioInBand, quadAudio;
  logic surroundAllowed, autoAudio, cableCoax;
  logic [6:0] fwdData;
  dpr_pkg::dpr_rate_t returnRate;
  int errCount = 0, nTests = 0;
  logic [7:0] dpTab [6] = '{8'h40, 8'h20, 8'h10, 8'h0D, 8'h09, 8'h03};
  always #10 sys_clk = ~sys_clk;
  dpr_remote_model remote_u (.sys_clk(sys_clk), .fwdLoad(fwdLoad),
    .fwdData(fwdData));
  dpr_regs dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .fwdLoad(fwdLoad), .fwdData(fwdData),
    .strapFastRate(1'b1), .strapCoax(1'b1), .strapRepeater(1'b1),
    .dataEnableIn(dataEnableIn), .colourPass(colourPass),
    .protectDisable(protectDisable), .audioOutEnable(audioOutEnable),
    .narrowColour(narrowColour), .audioInBand(audioInBand),
    .quadAudio(quadAudio), .surroundAllowed(surroundAllowed),
    .autoAudio(autoAudio), .cableCoax(cableCoax), .returnRate(returnRate));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 chk(regRdData, exp);
  endtask
  // decoded outputs land one cycle after the register, so wait an edge
  task automatic settle();
    @(posedge sys_clk);
    #1;
  endtask
  function automatic logic [7:0] expDec(input logic [7:0] v, input logic de);
    return {1'b0, v[6] | (de ^ v[5]), v[6], ~v[6] & ~v[4], v[2], v[1],
      v[3] & v[0], v[3] & v[0] & ~v[2]};
  endfunction
  task automatic printVerdict();
    if (errCount == 0 && nTests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(20 * 3000);
    errCount++;
    printVerdict();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rd(8'h22, dpr_pkg::DATAPATH_SETUP_RST);
    rd(8'h23, 8'h3C);
    chk({6'h00, returnRate}, {6'h00, dpr_pkg::RATE_20M});
    chk({autoAudio, cableCoax}, 8'h03);
    wr(8'h23, 8'hFF);
    rd(8'h23, 8'h7C);
    chk({6'h00, returnRate}, {6'h00, dpr_pkg::RATE_20M});
    wr(8'h23, 8'h40);
    settle();
    chk({6'h00, returnRate}, {6'h00, dpr_pkg::RATE_10M});
    rd(8'h23, 8'h44);
    wr(8'h23, 8'h00);
    settle();
    chk({6'h00, returnRate}, {6'h00, dpr_pkg::RATE_5M});
    chk({autoAudio, cableCoax}, 8'h00);
    // every datapath field below the lock bit, data enable driven both ways
    foreach (dpTab[i]) begin
      wr(8'h22, dpTab[i]);
      for (int de = 0; de < 2; de++) begin
        @(posedge sys_clk);
        dataEnableIn <= de[0];
        settle();
        chk({1'b0, colourPass, protectDisable, audioOutEnable, narrowColour,
          audioInBand, quadAudio, surroundAllowed},
          expDec(dpTab[i], de[0]));
      end
    end
    wr(8'h22, 8'h00);
    remote_u.sendConfig(7'h2A);
    rd(8'h22, 8'h2A);
    wr(8'h22, 8'h80);
    remote_u.sendConfig(7'h7F);
    rd(8'h22, 8'h80);
    wr(8'h24, 8'hFF);
    rd(8'h24, 8'h00);
    rd(8'h22, 8'h80);
    printVerdict();
  end
endmodule
`default_nettype wire
